// ==== inc/pcac_defines.svh ====
`ifndef PCAC_DEFINES_SVH
`define PCAC_DEFINES_SVH
// Core clock figures
`define PCAC_CLK_HZ 20000000
// Conversion periods in microseconds (10 Hz and 16.7 Hz)
`define PCAC_PERIOD_SLOW_US 100000
`define PCAC_PERIOD_FAST_US 60000
// Settling times in milliseconds
`define PCAC_SETTLE_SLOW_MS 300
`define PCAC_SETTLE_FAST_MS 120
// Oscillator start-up time in microseconds
`define PCAC_OSC_START_US 1000
// Serial word layout
`define PCAC_RESULT_W 20
`define PCAC_WORD_W 32
`define PCAC_ZERO_PAD 4'h0
// Transfer check patterns
`define PCAC_PAT_GOOD 2'h1
`define PCAC_PAT_BAD 2'h0
// Device identity bits, value arbitrary
`define PCAC_ID_BITS 2'h2
// Offset binary midscale code
`define PCAC_MIDSCALE 20'h80000
`endif

// ==== inc/pcac_pkg.sv ====
package pcac_pkg;
  typedef enum logic [1:0] {PCAC_OFF, PCAC_START, PCAC_SETTLE, PCAC_RUN} pcac_state_type;
  typedef struct packed {
    pcac_state_type st;
    logic [1:0] cfg_s1;
    logic [1:0] cfg_s2;
    logic [2:0] sclk_s;
    logic [22:0] cnt;
    logic [1:0] conv_left;
    logic [19:0] result;
    logic err;
    logic [31:0] shreg;
    logic [5:0] bits;
    logic ready_n;
    logic dout;
    logic bad_xfer;
    logic filt_cur;
    logic gain_cur;
  } pcac_regs_type;
endpackage

// ==== rtl/pcac_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcac_defines.svh"
// Operation
// - Filter pin low selects 16.7 Hz, high selects 10 Hz.
// - Filter pin change resets modulator and filter, ready high, restarts.
// - First result after full settling, then one per update period.
// - Settling is 300 ms for 10 Hz, 120 ms for 16.7 Hz.
// - Every completed conversion updates the result register.
// - Ready stays high after filter change until settling elapses.
// - Gain pin low selects 128, high selects 1.
// - Gain pin change resets conversion and holds ready high through settling.
// - First result after gain change follows full settling time.
// - Sleep pin low stops oscillator, opens bridge switch, floats data line.
// - Sleep pin low resets control, serial, filter and modulator.
// - After sleep release wait 1 ms, then sample, close switch, drive line.
// - Full internal reset happens automatically at power-up.
// - Results use offset binary coding, midscale is top bit set.
// - Result is 20 bits, code is 2^19 times one plus scaled input.
// - Data line goes low when a new result waits.
// - Read shifts 20-bit result, four zeros, then eight status bits.
// - Result read once; line high after read and before unread update.
// - Trailing check bits read 01 for good transfer, 00 for faulty.
module pcac_ctrl (
  // Clock and power-up reset
  input wire logic core_clk,
  input wire logic rst,
  // Configuration pins, asynchronous
  input wire logic sleep_clear_n,
  input wire logic filter_sel,
  input wire logic gain_sel,
  // Serial link clock from host, asynchronous
  input wire logic sclk,
  // Converted sample from modulator, offset binary, same clock
  input wire logic [19:0] sample_code,
  input wire logic sample_over,
  // Analog side controls
  output logic mod_run,
  output logic gain_is_128,
  output logic filter_is_slow,
  output logic bridge_low_side_switch,
  // Ready/data pin, two-signal form (data and enable); oe low means driving
  output logic dout_rdy_o,
  output logic dout_rdy_oe_n
);
  import pcac_pkg::*;

  localparam int unsigned CYC_PER_US = `PCAC_CLK_HZ / 1000000;
  localparam logic [22:0] SLOW_PERIOD = 23'(`PCAC_PERIOD_SLOW_US * CYC_PER_US);
  localparam logic [22:0] FAST_PERIOD = 23'(`PCAC_PERIOD_FAST_US * CYC_PER_US);
  localparam logic [22:0] OSC_START = 23'(`PCAC_OSC_START_US * CYC_PER_US);
  // All three spans fit in 23 bits: the longest is 2,000,000 core cycles.
  // A faster core clock would need a wider counter field in the package.

  // Settling as conversion counts
  // Settling expressed as conversion periods: 300/100 and 120/60
  // Keeping settling as a whole number of periods means the settle state
  // can share the update-rate timer instead of running a second counter.
  localparam logic [1:0] SLOW_CONV = 2'(`PCAC_SETTLE_SLOW_MS * 1000 / `PCAC_PERIOD_SLOW_US);
  localparam logic [1:0] FAST_CONV = 2'(`PCAC_SETTLE_FAST_MS * 1000 / `PCAC_PERIOD_FAST_US);

  pcac_regs_type q_r, q_nxt;

  // Period for the chosen filter
  function automatic logic [22:0] period_of(input logic slow);
    period_of = slow ? SLOW_PERIOD : FAST_PERIOD;
  endfunction

  // Conversions needed for settling
  function automatic logic [1:0] settle_of(input logic slow);
    settle_of = slow ? SLOW_CONV : FAST_CONV;
  endfunction

  // Check bits in status byte
  // Status byte appended to each read
  // Bit order: ready, filter, error, two identity bits, gain, two check bits.
  // The check bits report on the previous transfer, so a host that lost
  // clocks last time learns it from the next word.
  function automatic logic [7:0] status_of(input logic rdy, input logic slow, input logic err,
                                           input logic gain1, input logic bad);
    status_of = {rdy, slow, err, `PCAC_ID_BITS, gain1, bad ? `PCAC_PAT_BAD : `PCAC_PAT_GOOD};
  endfunction

  // Synchronised pin levels
  logic filt_hold;
  logic gain_hold;
  logic sleep_hold;
  // Levels as seen by the next-state logic
  logic filt_s;
  logic gain_s;
  // Serial clock edges found in the core clock domain
  logic sclk_rise;
  logic sclk_fall;
  // Pin change against the configuration in use
  logic cfg_change;
  // Settling conversions for the filter now on the pin
  logic [1:0] conv_cnt;
  // Two-stage synchroniser for sleep, filter and gain pins
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;

  // Only the second synchroniser stage is read by any logic
  assign filt_s = filt_hold;

  // Pin synchronisers kept apart from the struct to keep lanes clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {sleep_clear_n, filter_sel, gain_sel};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign sleep_hold = pin_s2_r[2];
  assign filt_hold = pin_s2_r[1];
  assign gain_hold = pin_s2_r[0];
  assign gain_s = gain_hold;
  // Serial clock passes stages 0 and 1; stage 2 is the delayed copy for edges.
  // The host clock is at least four core cycles per half period, so no
  // edge is lost; a faster link clock would need a faster core clock.
  assign sclk_rise = q_r.sclk_s[1] & ~q_r.sclk_s[2];
  assign sclk_fall = ~q_r.sclk_s[1] & q_r.sclk_s[2];
  assign conv_cnt = settle_of(filt_s);

  // Next-state logic for everything but the pin synchronisers
  always_comb begin
    q_nxt = q_r;
    q_nxt.sclk_s = {q_r.sclk_s[1:0], sclk};
    q_nxt.cfg_s1 = 2'h0;
    q_nxt.cfg_s2 = {1'b0, sleep_hold};
    cfg_change = (filt_s != q_r.filt_cur) || (gain_s != q_r.gain_cur);
    case (q_r.st)
      PCAC_OFF: begin
        q_nxt.ready_n = 1'b1;
        q_nxt.dout = 1'b1;
        q_nxt.bits = 6'h0;
        q_nxt.cnt = 23'h0;
        q_nxt.bad_xfer = 1'b0;
        q_nxt.result = `PCAC_MIDSCALE;
        if (sleep_hold) begin
          q_nxt.st = PCAC_START;
        end
      end
      PCAC_START: begin
        q_nxt.cnt = q_r.cnt + 23'h1;
        if (q_r.cnt == OSC_START - 23'h1) begin
          q_nxt.st = PCAC_SETTLE;
          q_nxt.cnt = 23'h0;
          q_nxt.filt_cur = filt_s;
          q_nxt.gain_cur = gain_s;
          q_nxt.conv_left = conv_cnt;
        end
      end
      PCAC_SETTLE, PCAC_RUN: begin
        q_nxt.cnt = q_r.cnt + 23'h1;
        // Shift out on falling link clock edges while a result waits
        if (!q_r.ready_n && sclk_fall && q_r.bits != 6'(`PCAC_WORD_W)) begin
          q_nxt.dout = q_r.shreg[31];
          q_nxt.shreg = {q_r.shreg[30:0], 1'b1};
          q_nxt.bits = q_r.bits + 6'h1;
        end
        // Line returns high once the word has gone out
        if (!q_r.ready_n && sclk_rise && q_r.bits == 6'(`PCAC_WORD_W)) begin
          q_nxt.ready_n = 1'b1;
          q_nxt.dout = 1'b1;
        end
        if (q_r.cnt == period_of(q_r.filt_cur) - 23'h2) begin
          // Unread result withdrawn just before update; partial read marked bad
          q_nxt.bad_xfer = (q_r.bits != 6'h0) && (q_r.bits != 6'(`PCAC_WORD_W));
          q_nxt.ready_n = 1'b1;
          q_nxt.dout = 1'b1;
        end
        if (q_r.cnt == period_of(q_r.filt_cur) - 23'h1) begin
          q_nxt.cnt = 23'h0;
          // Every conversion lands in the register
          q_nxt.result = sample_code;
          q_nxt.err = sample_over;
          q_nxt.bits = 6'h0;
          if (q_r.st == PCAC_SETTLE && q_r.conv_left > 2'h1) begin
            q_nxt.conv_left = q_r.conv_left - 2'h1;
          end else begin
            // Present the new word, ready low
            q_nxt.st = PCAC_RUN;
            q_nxt.ready_n = 1'b0;
            q_nxt.dout = 1'b0;
            q_nxt.shreg = {sample_code, `PCAC_ZERO_PAD,
                           status_of(1'b0, q_r.filt_cur, sample_over, q_r.gain_cur, q_r.bad_xfer)};
          end
        end
        // Restart on config change, ready forced high
        if (cfg_change) begin
          q_nxt.st = PCAC_SETTLE;
          q_nxt.cnt = 23'h0;
          q_nxt.filt_cur = filt_s;
          q_nxt.gain_cur = gain_s;
          q_nxt.conv_left = conv_cnt;
          q_nxt.ready_n = 1'b1;
          q_nxt.dout = 1'b1;
          q_nxt.bits = 6'h0;
        end
      end
      default: q_nxt.st = PCAC_OFF;
    endcase
    if (!sleep_hold) begin
      q_nxt.st = PCAC_OFF;
      q_nxt.cnt = 23'h0;
    end
  end

  // Power-up reset clears state
  // The serial clock stages reset to its idle high level, so the first
  // sample after reset cannot be mistaken for a rising edge.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q_r <= '{
        st: PCAC_OFF,
        cfg_s1: 2'h0,
        cfg_s2: 2'h0,
        sclk_s: 3'h7,
        cnt: 23'h0,
        conv_left: 2'h0,
        result: `PCAC_MIDSCALE,
        err: 1'b0,
        shreg: 32'h0,
        bits: 6'h0,
        ready_n: 1'b1,
        dout: 1'b1,
        bad_xfer: 1'b0,
        filt_cur: 1'b0,
        gain_cur: 1'b0
      };
    end else begin
      q_r <= q_nxt;
    end
  end

  // Config to analog side
  // These follow the configuration in use, not the raw pins, so the analog
  // side switches in the same cycle as the modulator restart.
  assign filter_is_slow = q_r.filt_cur;
  assign gain_is_128 = ~q_r.gain_cur;
  // Bridge switch and modulator only after start-up
  assign mod_run = (q_r.st == PCAC_SETTLE) || (q_r.st == PCAC_RUN);
  assign bridge_low_side_switch = mod_run;
  assign dout_rdy_o = q_r.dout;
  assign dout_rdy_oe_n = ~mod_run;
endmodule // pcac_ctrl
`default_nettype wire

// ==== tb/pcac_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcac_ctrl_chk (
  // Clock, reset and pins
  input wire logic core_clk, input wire logic rst, input wire logic sleep_clear_n,
  input wire logic filter_sel, input wire logic gain_sel,
  // Device outputs
  input wire logic mod_run, input wire logic gain_is_128, input wire logic filter_is_slow,
  input wire logic bridge_low_side_switch, input wire logic dout_rdy_o, input wire logic dout_rdy_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] wake_r;
  // Awake-but-idle cycles; saturates so a long wait cannot wrap
  always_ff @(posedge core_clk) begin
    wake_r <= (rst || mod_run || !sleep_clear_n) ? 16'h0 : wake_r + {15'h0, wake_r != 16'hffff};
  end
  // Config flip while converting, then forced-high line
  sequence cfg_flip_s;
    mod_run && ($changed(gain_sel) || $changed(filter_sel));
  endsequence
  sequence line_high_s;
    (dout_rdy_o && !dout_rdy_oe_n) [*8];
  endsequence
  bridge_eq_a: assert property (bridge_low_side_switch == mod_run) else $error("switch not tied to run");
  float_off_a: assert property (!mod_run |-> dout_rdy_oe_n) else $error("line driven while off");
  sleep_off_a: assert property (!sleep_clear_n [*5] |-> !mod_run) else $error("still running in sleep");
  gain_pick_a: assert property ((mod_run && $stable(gain_sel)) [*6] |-> gain_is_128 == !gain_sel)
    else $error("gain level wrong");
  filt_pick_a: assert property ((mod_run && $stable(filter_sel)) [*6] |-> filter_is_slow == filter_sel)
    else $error("filter level wrong");
  cfg_ready_a: assert property (cfg_flip_s |-> ##[1:6] line_high_s) else $error("line not held high");
  wake_min_a: assert property ($rose(mod_run) |-> wake_r >= 16'h4e16) else $error("woke too early");
  wake_max_a: assert property (wake_r <= 16'h4e48) else $error("woke too late");
endmodule // pcac_ctrl_chk
bind pcac_ctrl pcac_ctrl_chk pcac_ctrl_chk_inst (.core_clk(core_clk), .rst(rst), .sleep_clear_n(sleep_clear_n),
  .filter_sel(filter_sel), .gain_sel(gain_sel), .mod_run(mod_run), .gain_is_128(gain_is_128),
  .filter_is_slow(filter_is_slow), .bridge_low_side_switch(bridge_low_side_switch),
  .dout_rdy_o(dout_rdy_o), .dout_rdy_oe_n(dout_rdy_oe_n));
`default_nettype wire

// ==== tb/pcac_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcac_host_model (
  // Burst request from the bench
  input wire logic burst,
  // Serial clock; idles high between frames
  output logic sclk
);
  // 400 ns link period, only while a burst is asked for
  initial begin
    sclk = 1'b1;
    forever begin
      wait (burst);
      #200 sclk = 1'b0;
      #200 sclk = 1'b1;
    end
  end
endmodule // pcac_host_model
`default_nettype wire

// ==== tb/pcac_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcac_ctrl_tb;
  logic core_clk, rst, sleep_clear_n, filter_sel, gain_sel, sclk, burst, sample_over;
  logic [19:0] sample_code;
  logic mod_run, gain_is_128, filter_is_slow, bridge_low_side_switch, dout_rdy_o, dout_rdy_oe_n;
  int bad_count;
  int samples_checked;
  pcac_ctrl pcac_ctrl_inst (.core_clk(core_clk), .rst(rst), .sleep_clear_n(sleep_clear_n),
    .filter_sel(filter_sel), .gain_sel(gain_sel), .sclk(sclk), .sample_code(sample_code),
    .sample_over(sample_over), .mod_run(mod_run), .gain_is_128(gain_is_128), .filter_is_slow(filter_is_slow),
    .bridge_low_side_switch(bridge_low_side_switch), .dout_rdy_o(dout_rdy_o), .dout_rdy_oe_n(dout_rdy_oe_n));
  pcac_host_model pcac_host_model_inst (.burst(burst), .sclk(sclk));
  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Single-bit compare
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Inputs only move on the falling edge
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Powered down: switch open, line floating
  task automatic chk_off;
    chk(mod_run, 1'b0);
    chk(bridge_low_side_switch, 1'b0);
    chk(dout_rdy_oe_n, 1'b1);
  endtask
  // Awake and settling: line driven but still high
  task automatic chk_settle;
    chk(mod_run, 1'b1);
    chk(bridge_low_side_switch, 1'b1);
    chk(dout_rdy_oe_n, 1'b0);
    chk(dout_rdy_o, 1'b1);
  endtask
  // Main sequence
  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    sleep_clear_n = 1'b1;
    filter_sel = 1'b0;
    gain_sel = 1'b0;
    burst = 1'b0;
    sample_over = 1'b0;
    sample_code = 20'h80000;
    idle(12);
    chk_off();
    rst = 1'b0;
    idle(20100);
    chk_settle();
    // No read in flight at pin change
    // Walk all four pin settings; each change restarts settling
    for (int i = 1; i < 5; i++) begin
      filter_sel = i[0];
      gain_sel = i[1];
      idle(10);
      chk(filter_is_slow, i[0]);
      chk(gain_is_128, ~i[1]);
      chk(dout_rdy_o, 1'b1);
    end
    // Clocks while not ready must be ignored
    burst = 1'b1;
    idle(40);
    burst = 1'b0;
    idle(4);
    chk(dout_rdy_o, 1'b1);
    sleep_clear_n = 1'b0;
    idle(10);
    chk_off();
    sleep_clear_n = 1'b1;
    idle(100);
    chk_off();
    // Host trusts no result inside settling
    idle(20000);
    chk_settle();
    close_out();
  end
  // Watchdog a little past the planned run of about 2 ms
  initial begin
    #2500000;
    bad_count++;
    close_out();
  end
endmodule // pcac_ctrl_tb
`default_nettype wire
